// ==== core/config_preload_word_map.sv ====
// Summary of operation
// - pm words ports 2-5 at 84h..8Ah
// - word bit 6 to 74h bit 14
// - word bits 5:0 to 74h bits 13:8
// - word bit 7 to 70h bit 31
// - word upper byte to 88h bits 31:24
// - slot low words from 92h to D4h[15:0]
// - slot high words A2h..AAh to D4h[31:16]
// - word B0h to port 0 80h[15:0]
// - pm words ports 0,1 at 80h, 82h
// - word B2h to port 1 80h[15:0]
`timescale 1ns/1ps
`default_nettype none
module config_preload_word_map
  import preload_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // preload word stream from the store reader
  input wire logic word_valid_in,
  input wire logic [WADDR_W-1:0] word_addr_in,
  input wire logic [WORD_W-1:0] word_data_in,
  input wire logic load_end_in,
  output logic word_ready_out,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // status
  output logic load_done_out
);

  // ------------------------------------------------------------
  // word address decode
  // ------------------------------------------------------------
  // odd addresses and words of other jobs fall through as none
  function automatic word_kind_e word_kind(input logic [WADDR_W-1:0] a);
    word_kind_e k;
    k = KIND_NONE;
    if (a[0] == 1'b0) begin
      if (a >= PM_WORD_BASE && a <= PM_WORD_LAST) begin
        k = KIND_PM;
      end else if (a >= SLOT_LO_BASE && a <= SLOT_LO_LAST) begin
        k = KIND_SLOT_LO;
      end else if (a >= SLOT_HI_BASE && a <= SLOT_HI_LAST) begin
        k = KIND_SLOT_HI;
      end else if (a >= VEND_A_BASE && a <= VEND_A_LAST) begin
        k = KIND_VEND_A;
      end
    end
    return k;
  endfunction

  // port index from word address, stride of two per port
  function automatic logic [2:0] word_port(input logic [WADDR_W-1:0] a, input word_kind_e k);
    logic [WADDR_W-1:0] rel;
    rel = '0;
    case (k)
      KIND_PM: rel = a - PM_WORD_BASE;
      KIND_SLOT_LO: rel = a - SLOT_LO_BASE + {4'h0, SLOT_FIRST_PORT, 1'b0};
      KIND_SLOT_HI: rel = a - SLOT_HI_BASE + {4'h0, SLOT_FIRST_PORT, 1'b0};
      KIND_VEND_A: rel = a - VEND_A_BASE;
      default: rel = '0;
    endcase
    return rel[3:1];
  endfunction

  // ------------------------------------------------------------
  // fifo between reader and applier
  // ------------------------------------------------------------
  word_stream_if #(.WIDTH(ENTRY_W)) in_stream ();
  word_stream_if #(.WIDTH(ENTRY_W)) out_stream ();

  assign in_stream.valid = word_valid_in;
  assign in_stream.data = {word_addr_in, word_data_in};
  assign word_ready_out = in_stream.ready;

  preload_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .fill(in_stream),
    .drain(out_stream)
  );

  logic apply_en;
  logic end_seen;
  load_phase_e phase;
  logic apb_wr_access;
  logic apply;
  logic [WADDR_W-1:0] head_addr;
  logic [WORD_W-1:0] head_data;
  word_kind_e head_kind;
  logic [2:0] head_port;
  logic bus_busy;

  // a bus access that can finish this cycle stalls the applier:
  // a write then never meets a preloaded word on one register, and the
  // read copy taken at the setup edge still stands at the access edge;
  // a port access held off during the load must not stall, or the
  // buffer could never drain and the access would wait for ever
  assign apb_wr_access = psel && penable && pwrite;
  assign bus_busy = psel && pready;
  assign out_stream.ready = apply_en && !bus_busy;
  assign apply = out_stream.valid && out_stream.ready;

  // head entry split and decoded once, shared by every port
  assign head_addr = out_stream.data[ENTRY_W-1:WORD_W];
  assign head_data = out_stream.data[WORD_W-1:0];
  assign head_kind = word_kind(head_addr);
  assign head_port = word_port(head_addr, head_kind);

  // ------------------------------------------------------------
  // load phase
  // ------------------------------------------------------------
  // end marker is sticky; it may arrive before the fifo has drained
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      end_seen <= 1'b0;
    end else if (load_end_in) begin
      end_seen <= 1'b1;
    end
  end

  // ready only once the end is seen and every word is applied
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase <= PH_LOADING;
    end else begin
      case (phase)
        PH_LOADING: begin
          if (end_seen && !out_stream.valid) begin
            phase <= PH_READY;
          end
        end
        PH_READY: phase <= PH_READY;
        default: phase <= PH_LOADING;
      endcase
    end
  end

  // status is the phase itself, so it needs no flip-flop of its own
  assign load_done_out = (phase == PH_READY);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [2:0] bus_port;
  logic [7:0] bus_off;
  logic bus_ctrl;
  logic bus_port_hit;
  logic bus_hit;
  logic wr_done;

  assign bus_port = paddr[10:8];
  assign bus_off = paddr[7:0];
  assign bus_ctrl = (paddr == LOADER_CTRL_ADDR);
  assign bus_port_hit = !paddr[11] && (bus_port < 3'(NUM_PORTS)) &&
                        (bus_off == VGA_TIMER_OFF || bus_off == PWR_MGMT_OFF ||
                         bus_off == VEND_A_OFF || bus_off == VEND_B_OFF ||
                         bus_off == SLOT_CAP_OFF);
  assign bus_hit = bus_ctrl || bus_port_hit;
  // port register accesses wait out the load; control is always open
  assign pready = !(bus_port_hit && phase == PH_LOADING);
  assign pslverr = psel && penable && !bus_hit;
  assign wr_done = apb_wr_access && pready && bus_hit;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // clearing the enable freezes the applier and lets the fifo fill
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      apply_en <= APPLY_EN_RST;
    end else if (wr_done && bus_ctrl) begin
      apply_en <= pwdata[CTRL_EN_BIT];
    end
  end

  // ------------------------------------------------------------
  // per-port registers
  // ------------------------------------------------------------
  logic [31:0] vga_timer [NUM_PORTS];
  logic [31:0] pwr_mgmt [NUM_PORTS];
  logic [31:0] vend_a [NUM_PORTS];
  logic [31:0] vend_b [NUM_PORTS];
  logic [31:0] slot_cap [NUM_PORTS];

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic pm_hit;
    logic wr_here;
    // strobes for this port: a preload word, or a bus write
    assign pm_hit = apply && head_kind == KIND_PM && head_port == 3'(p);
    assign wr_here = wr_done && bus_port_hit && bus_port == 3'(p);

    // vga decode enable bit
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        vga_timer[p] <= VGA_TIMER_RST;
      end else if (wr_here && bus_off == VGA_TIMER_OFF) begin
        vga_timer[p] <= pwdata;
      end else if (pm_hit) begin
        vga_timer[p][VGA_DST] <= head_data[VGA_SRC];
      end
    end

    // power management control fields
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        pwr_mgmt[p] <= PWR_MGMT_RST;
      end else if (wr_here && bus_off == PWR_MGMT_OFF) begin
        pwr_mgmt[p] <= pwdata;
      end else if (pm_hit) begin
        pwr_mgmt[p][PM_RXPOL_DST] <= head_data[PM_RXPOL_SRC];
        pwr_mgmt[p][PM_FIELD_DST_LO +: PM_FIELD_W] <=
          head_data[PM_FIELD_SRC_LO +: PM_FIELD_W];
      end
    end

    // vendor control upper byte
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        vend_b[p] <= VEND_B_RST;
      end else if (wr_here && bus_off == VEND_B_OFF) begin
        vend_b[p] <= pwdata;
      end else if (pm_hit) begin
        vend_b[p][VEND_B_DST_LO +: BYTE_W] <= head_data[VEND_B_SRC_LO +: BYTE_W];
      end
    end

    // vendor control low half, only ports 0 and 1 are preloaded here
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        vend_a[p] <= VEND_A_RST;
      end else if (wr_here && bus_off == VEND_A_OFF) begin
        vend_a[p] <= pwdata;
      end else if (apply && head_kind == KIND_VEND_A && head_port == 3'(p)) begin
        vend_a[p][HALF_W-1:0] <= head_data;
      end
    end

    // slot capabilities, low and high halves
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        slot_cap[p] <= SLOT_CAP_RST;
      end else if (wr_here && bus_off == SLOT_CAP_OFF) begin
        slot_cap[p] <= pwdata;
      end else if (apply && head_port == 3'(p)) begin
        if (head_kind == KIND_SLOT_LO) begin
          slot_cap[p][HALF_W-1:0] <= head_data;
        end else if (head_kind == KIND_SLOT_HI) begin
          slot_cap[p][31:HALF_W] <= head_data;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] next_prdata;

  // read mux; the applier is held whenever a selected access can finish,
  // so the copy registered at the setup edge matches the access edge;
  // the done bit alone may turn one cycle after that copy is taken
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (bus_ctrl) begin
      next_prdata[CTRL_DONE_BIT] = load_done_out;
      next_prdata[CTRL_EN_BIT] = apply_en;
    end else if (bus_port_hit) begin
      case (bus_off)
        VGA_TIMER_OFF: next_prdata = vga_timer[bus_port];
        PWR_MGMT_OFF: next_prdata = pwr_mgmt[bus_port];
        VEND_A_OFF: next_prdata = vend_a[bus_port];
        VEND_B_OFF: next_prdata = vend_b[bus_port];
        SLOT_CAP_OFF: next_prdata = slot_cap[bus_port];
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // read data flip-flop, reloaded on every selected cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      prdata <= 32'h0000_0000;
    end else if (psel) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// ==== core/preload_pkg.sv ====
package preload_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int WORD_W = 16;
  localparam int WADDR_W = 8;
  localparam int ENTRY_W = WORD_W + WADDR_W;
  localparam int FIFO_DEPTH = 4;
  localparam int PADDR_W = 12;

  // ------------------------------------------------------------
  // preload word addresses (word index in the store)
  // ------------------------------------------------------------
  localparam logic [7:0] PM_WORD_BASE = 8'h80;
  localparam logic [7:0] PM_WORD_LAST = 8'h8A;
  localparam logic [7:0] SLOT_LO_BASE = 8'h92;
  localparam logic [7:0] SLOT_LO_LAST = 8'h9A;
  localparam logic [7:0] SLOT_HI_BASE = 8'hA2;
  localparam logic [7:0] SLOT_HI_LAST = 8'hAA;
  localparam logic [7:0] VEND_A_BASE = 8'hB0;
  localparam logic [7:0] VEND_A_LAST = 8'hB2;
  localparam logic [2:0] SLOT_FIRST_PORT = 3'h1;

  // ------------------------------------------------------------
  // per-port configuration offsets
  // ------------------------------------------------------------
  localparam logic [7:0] VGA_TIMER_OFF = 8'h70;
  localparam logic [7:0] PWR_MGMT_OFF = 8'h74;
  localparam logic [7:0] VEND_A_OFF = 8'h80;
  localparam logic [7:0] VEND_B_OFF = 8'h88;
  localparam logic [7:0] SLOT_CAP_OFF = 8'hD4;
  localparam logic [PADDR_W-1:0] LOADER_CTRL_ADDR = 12'h600;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PM_RXPOL_SRC = 6;
  localparam int PM_RXPOL_DST = 14;
  localparam int PM_FIELD_SRC_LO = 0;
  localparam int PM_FIELD_W = 6;
  localparam int PM_FIELD_DST_LO = 8;
  localparam int VGA_SRC = 7;
  localparam int VGA_DST = 31;
  localparam int VEND_B_SRC_LO = 8;
  localparam int VEND_B_DST_LO = 24;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int CTRL_DONE_BIT = 0;
  localparam int CTRL_EN_BIT = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] VGA_TIMER_RST = 32'h0000_0000;
  localparam logic [31:0] PWR_MGMT_RST = 32'h0000_0000;
  localparam logic [31:0] VEND_A_RST = 32'h0000_0000;
  localparam logic [31:0] VEND_B_RST = 32'h0000_0000;
  localparam logic [31:0] SLOT_CAP_RST = 32'h0000_0000;
  localparam logic APPLY_EN_RST = 1'b1;

  // ------------------------------------------------------------
  // word kinds and loader phase
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    KIND_NONE = 5'b00001,
    KIND_PM = 5'b00010,
    KIND_SLOT_LO = 5'b00100,
    KIND_SLOT_HI = 5'b01000,
    KIND_VEND_A = 5'b10000
  } word_kind_e;

  typedef enum logic [1:0] {
    PH_LOADING = 2'b01,
    PH_READY = 2'b10
  } load_phase_e;

endpackage

// ==== core/word_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 24);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== core/preload_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module preload_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // fill and drain sides
  word_stream_if.snk fill,
  word_stream_if.src drain
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  // honest flags: full stalls the source, empty hides the head
  assign fill.ready = (count != (PTR_W+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // storage, written by index
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // pointers wrap on depth, which is a power of two
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/config_preload_word_map_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module preload_map_checker
  import preload_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // word stream
  input wire logic word_valid_in,
  input wire logic word_ready_out,
  input wire logic load_done_out,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // access phase and power-management register decode, ports 0 to 5
  wire logic acc = psel && penable;
  wire logic pm_reg = paddr[11:8] < 4'h6 && paddr[7:0] == PWR_MGMT_OFF;
  a_ctrl_no_wait: assert property (acc && paddr == LOADER_CTRL_ADDR |-> pready && !pslverr)
    else $error("control access stalled");
  a_port_blocked: assert property (acc && pm_reg && !load_done_out |-> !pready)
    else $error("port access before load done");
  a_port_open: assert property (acc && pm_reg && load_done_out |-> pready && !pslverr)
    else $error("port access refused after load");
  a_unmapped_err: assert property (acc && paddr[11:8] > 4'h6 |-> pready && pslverr)
    else $error("unmapped access not refused");
  a_err_access: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_done_sticky: assert property (load_done_out |=> load_done_out)
    else $error("load done dropped");
  a_done_empty: assert property ($rose(load_done_out) |-> word_ready_out)
    else $error("done with buffer full");
  // first edge after release must still show reset state
  a_reset_clean: assert property ($fell(srst_in) |-> word_ready_out && !load_done_out
    && prdata == 32'h0000_0000)
    else $error("state not clean after reset");
  a_rdata_hold: assert property (!psel && !$past(psel) |-> $stable(prdata))
    else $error("read data moved while idle");
  c_unmapped: cover property (acc && pslverr);
  c_wait: cover property (acc && !pready);
  c_full: cover property (word_valid_in && !word_ready_out);
endmodule
bind config_preload_word_map preload_map_checker chk_i (
  .mclk_in(mclk_in), .srst_in(srst_in), .word_valid_in(word_valid_in),
  .word_ready_out(word_ready_out), .load_done_out(load_done_out), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata));
`default_nettype wire

// ==== bench/word_store_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module word_store_model
  import preload_pkg::*;
#(parameter int N = 12)
(
  // clock
  input wire logic mclk_in,
  // control from bench
  input wire logic start_in,
  input wire logic gap_in,
  input wire logic [ENTRY_W-1:0] table_in [N],
  // word stream
  input wire logic word_ready_in,
  output logic word_valid_out,
  output logic [WADDR_W-1:0] word_addr_out,
  output logic [WORD_W-1:0] word_data_out,
  output logic load_end_out,
  output logic [7:0] sent_out
);
  // ----------------------------------------
  // store reader
  // ----------------------------------------
  // word held until taken; idle lines show the inverse so stale data never looks valid
  initial begin
    word_valid_out = 1'b0;
    word_addr_out = '0;
    word_data_out = '0;
    load_end_out = 1'b0;
    sent_out = '0;
    wait (start_in === 1'b1);
    for (int i = 0; i < N; i++) begin
      if (i == 0 || gap_in) @(posedge mclk_in);
      word_valid_out <= 1'b1;
      {word_addr_out, word_data_out} <= table_in[i];
      do @(posedge mclk_in); while (word_ready_in !== 1'b1);
      sent_out <= sent_out + 8'h01;
      if (gap_in || i == N - 1) begin
        word_valid_out <= 1'b0;
        {word_addr_out, word_data_out} <= ~table_in[i];
      end
    end
    load_end_out <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import preload_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk_in, srst_in, psel, penable, pwrite, pready, pslverr, err, start, gap;
  logic word_valid, word_ready, load_end, load_done_out;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [WADDR_W-1:0] word_addr;
  logic [WORD_W-1:0] word_data;
  logic [7:0] sent;
  logic [ENTRY_W-1:0] tbl [12];
  logic [31:0] exp_reg [6][5];
  logic [7:0] off [5];
  int n_fail, checked, n;
  config_preload_word_map DUT (
    .mclk_in(mclk_in), .srst_in(srst_in), .word_valid_in(word_valid),
    .word_addr_in(word_addr), .word_data_in(word_data), .load_end_in(load_end),
    .word_ready_out(word_ready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .load_done_out(load_done_out));
  word_store_model #(.N(12)) store (
    .mclk_in(mclk_in), .start_in(start), .gap_in(gap), .table_in(tbl),
    .word_ready_in(word_ready), .word_valid_out(word_valid), .word_addr_out(word_addr),
    .word_data_out(word_data), .load_end_out(load_end), .sent_out(sent));
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // apb master: hold the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      w++;
    end while (pready !== 1'b1 && w < 200);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 200) n_fail++;
  endtask
  // expected register image, worked out word by word in store order
  task automatic apply(input logic [ENTRY_W-1:0] e);
    logic [7:0] a;
    logic [15:0] d;
    a = e[23:16];
    d = e[15:0];
    if (!a[0] && a >= 8'h80 && a <= 8'h8A) begin
      exp_reg[(a - 8'h80) / 2][1] = {17'h0, d[6], d[5:0], 8'h00};
      exp_reg[(a - 8'h80) / 2][0] = {d[7], 31'h0};
      exp_reg[(a - 8'h80) / 2][3] = {d[15:8], 24'h00_0000};
    end
    if (!a[0] && a >= 8'h92 && a <= 8'h9A) exp_reg[1 + (a - 8'h92) / 2][4][15:0] = d;
    if (!a[0] && a >= 8'hA2 && a <= 8'hAA) exp_reg[1 + (a - 8'hA2) / 2][4][31:16] = d;
    if (!a[0] && a >= 8'hB0 && a <= 8'hB2) exp_reg[(a - 8'hB0) / 2][2][15:0] = d;
  endtask
  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  // watchdog: the whole run needs under two hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    print_verdict();
  end
  initial begin
    {srst_in, psel, penable, pwrite, start, gap} = 6'b10_0000;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    checked = 0;
    tbl = '{24'h80_F07F, 24'h82_1234, 24'h84_0011, 24'h8A_00BF, 24'h92_BEEF, 24'h9A_1357,
      24'hA2_CAFE, 24'hAA_2468, 24'hB0_55AA, 24'hB2_0F0F, 24'h85_FFFF, 24'h84_A5C3};
    off = '{VGA_TIMER_OFF, PWR_MGMT_OFF, VEND_A_OFF, VEND_B_OFF, SLOT_CAP_OFF};
    exp_reg = '{default: '{default: 32'h0000_0000}};
    foreach (tbl[i]) apply(tbl[i]);
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    apb(1'b0, LOADER_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 12'h700, 32'h0);
    chk({rd[30:0], err}, 32'h0000_0001);
    // freeze the applier so the buffer fills and refuses the fifth word
    apb(1'b1, LOADER_CTRL_ADDR, 32'h0);
    start <= 1'b1;
    repeat (20) @(posedge mclk_in);
    chk({22'h0, word_ready, load_done_out, sent}, 32'h0000_0004);
    gap <= 1'b1;
    apb(1'b1, LOADER_CTRL_ADDR, 32'h0000_0002);
    // a port read issued mid-load is held off until every word is applied
    apb(1'b0, {4'h0, PWR_MGMT_OFF}, 32'h0);
    chk(rd, exp_reg[0][1]);
    n = 0;
    while (load_done_out !== 1'b1 && n < 1000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 1000) n_fail++;
    apb(1'b0, LOADER_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0003);
    for (int p = 0; p < 6; p++) begin
      for (int k = 0; k < 5; k++) begin
        apb(1'b0, {4'(p), off[k]}, 32'h0);
        chk({rd[30:0], err}, {exp_reg[p][k][30:0], 1'b0});
        chk({31'h0, rd[31]}, {31'h0, exp_reg[p][k][31]});
      end
    end
    apb(1'b1, 12'h374, 32'h1234_5678);
    apb(1'b0, 12'h374, 32'h0);
    chk(rd, 32'h1234_5678);
    print_verdict();
  end
endmodule
`default_nettype wire
